// ==== include/npec_pkg.sv ====
// shared constants, types and register layout of the nvm program/erase controller
package npec_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ERASE_TIME_NS = 2000;
  localparam int unsigned PROG_TIME_NS = 2000;
  localparam int unsigned WORD_TIME_NS = 4000;
  // least times, rounded up to whole cycles
  localparam logic [15:0] ERASE_CYC = 16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PROG_CYC = 16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] WORD_CYC = 16'((WORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL_A = 6'h00;
  localparam logic [5:0] IDX_CTRL_B = 6'h01;
  localparam logic [5:0] IDX_PKEY = 6'h02;
  localparam logic [5:0] IDX_DKEY = 6'h03;
  localparam logic [5:0] IDX_STATUS = 6'h04;
  localparam logic [5:0] IDX_EVT_STAT = 6'h05;
  localparam logic [5:0] IDX_EVT_MASK = 6'h06;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CA_IRQ_EN = 1;
  localparam int unsigned CB_OPT = 7;
  localparam int unsigned CB_WORD = 6;
  localparam int unsigned CB_ERASE = 5;
  localparam int unsigned CB_FAST = 4;
  localparam int unsigned CB_STD = 0;
  localparam int unsigned ST_HIGH_VOLTAGE_OFF_FLAG = 6;
  localparam int unsigned ST_DUL = 3;
  localparam int unsigned ST_EOP = 2;
  localparam int unsigned ST_PUL = 1;
  localparam int unsigned ST_WPA = 0;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_WPA = 1;
  localparam int unsigned EV_PUL = 2;
  localparam int unsigned EV_DUL = 3;
  localparam int unsigned EV_W = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [3:0] CTRL_A_RST = 4'h0;
  localparam logic [EV_W-1:0] EVT_MASK_RST = 4'h0;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AREA_PROG = 2'h0,
    AREA_DATA = 2'h1,
    AREA_OPT = 2'h2
  } npec_area_type;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_HALF = 3'b010,
    KEY_DEAD = 3'b100
  } npec_key_state_type;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_ERASE = 3'b010,
    OP_PROG = 3'b100
  } npec_op_state_type;

  // ---------------------------------------------------------------
  // carriers and state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    npec_area_type area;
  } npec_mem_req_type;

  typedef struct packed {
    logic busy;
    logic hv_on;
    logic accept;
  } npec_mem_stat_type;

  typedef struct packed {
    npec_key_state_type st;
    logic unlock;
  } npec_key_type;

  typedef struct packed {
    logic [3:0] ctrl_a;
    logic option_write_enable;
    logic word;
    logic erase;
    logic fast;
    logic std;
    logic data_area_unlocked_flag;
    logic pul;
    logic eop;
    logic wpa;
    logic [EV_W-1:0] evt;
    logic [EV_W-1:0] mask;
    npec_op_state_type op;
    logic [15:0] cnt;
    logic accept;
    logic [7:0] rdata;
    logic slverr;
  } npec_state_type;

endpackage

// ==== logic/npec_key_check.sv ====
// two-byte unlock key sequence checker
`timescale 1ns/1ns
module npec_key_check #(
  parameter logic [7:0] KEY_FIRST = 8'h3c, // arbitrary value
  parameter logic [7:0] KEY_SECOND = 8'hc3, // arbitrary value
  parameter bit ONE_SHOT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic key_wr,
  input wire logic [7:0] key_byte,
  output logic unlock
);

  npec_pkg::npec_key_type r_reg;
  npec_pkg::npec_key_type r_next;

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  // a wrong byte locks for good in one-shot mode, else restarts
  always_comb begin
    r_next = r_reg;
    r_next.unlock = 1'b0;
    case (r_reg.st)
      npec_pkg::KEY_IDLE: begin
        if (key_wr) begin
          if (key_byte == KEY_FIRST) begin
            r_next.st = npec_pkg::KEY_HALF;
          end else if (ONE_SHOT) begin
            r_next.st = npec_pkg::KEY_DEAD; // R16
          end
        end
      end
      npec_pkg::KEY_HALF: begin
        if (key_wr) begin
          if (key_byte == KEY_SECOND) begin
            r_next.unlock = 1'b1;
            // only one unlock until reset in one-shot mode
            r_next.st = ONE_SHOT ? npec_pkg::KEY_DEAD : npec_pkg::KEY_IDLE; // R16
          end else begin
            r_next.st = ONE_SHOT ? npec_pkg::KEY_DEAD : npec_pkg::KEY_IDLE; // R17
          end
        end
      end
      npec_pkg::KEY_DEAD: begin
        r_next.st = npec_pkg::KEY_DEAD;
      end
      default: begin
        r_next.st = npec_pkg::KEY_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{st: npec_pkg::KEY_IDLE, unlock: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign unlock = r_reg.unlock;

endmodule

// ==== logic/npec_ctrl.sv ====
// nvm program/erase controller with apb registers
//
// Function
// R1: option byte writes allowed only while option_write_enable is set.
// R2: word_program_request arms word program; hardware clears it on completion.
// R3: erase request arms block erase; hardware clears it on completion.
// R4: fast_block_program_request arms program without erase; cleared on completion.
// R5: standard_block_program_request erases then programs; cleared on completion.
// R6: erase and fast request bits ignore writes while busy.
// R7: program key register takes byte writes always, reads as zero.
// R8: data key register takes byte writes always, reads as zero.
// R9: high_voltage_off_flag low while high voltage on, high otherwise.
// R10: correct data keys set data unlock flag; writing 0 clears it.
// R11: correct program keys set program unlock flag; writing 0 clears it.
// R12: done flag set at operation end; cleared by status read or new start.
// R13: protected write attempt sets flag; status read clears it.
// R14: interrupt when irq_enable and done or protected write flag set.
// R15: status resets to 0x40; other registers reset to zero.
// R16: program area unlocks once per reset; wrong keys lock until reset.
// R17: wrong data keys allow a fresh key sequence without reset.
// R18: software arms one request at a time and waits for its clear.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module npec_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire npec_pkg::npec_mem_req_type mem_req,
  output npec_pkg::npec_mem_stat_type mem_stat,
  output logic irq
);

  npec_pkg::npec_state_type r_reg;
  npec_pkg::npec_state_type r_next;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // true when the byte address selects the register of this index
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic [5:0] idx
  );
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic busy;
  logic mapped;
  logic wr_a;
  logic wr_b;
  logic wr_pkey;
  logic wr_dkey;
  logic wr_stat;
  logic wr_evt;
  logic wr_mask;
  logic rd_stat;

  // bus phases; the slave never inserts wait states
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign busy = (r_reg.op != npec_pkg::OP_IDLE);

  // register selects for the access phase
  assign wr_a = acc_wr & reg_hit(paddr, npec_pkg::IDX_CTRL_A);
  assign wr_b = acc_wr & reg_hit(paddr, npec_pkg::IDX_CTRL_B);
  assign wr_pkey = acc_wr & reg_hit(paddr, npec_pkg::IDX_PKEY);
  assign wr_dkey = acc_wr & reg_hit(paddr, npec_pkg::IDX_DKEY);
  assign wr_stat = acc_wr & reg_hit(paddr, npec_pkg::IDX_STATUS);
  assign wr_evt = acc_wr & reg_hit(paddr, npec_pkg::IDX_EVT_STAT);
  assign wr_mask = acc_wr & reg_hit(paddr, npec_pkg::IDX_EVT_MASK);
  assign rd_stat = acc_rd & reg_hit(paddr, npec_pkg::IDX_STATUS);

  // any of the seven words
  assign mapped = reg_hit(paddr, npec_pkg::IDX_CTRL_A)
                | reg_hit(paddr, npec_pkg::IDX_CTRL_B)
                | reg_hit(paddr, npec_pkg::IDX_PKEY)
                | reg_hit(paddr, npec_pkg::IDX_DKEY)
                | reg_hit(paddr, npec_pkg::IDX_STATUS)
                | reg_hit(paddr, npec_pkg::IDX_EVT_STAT)
                | reg_hit(paddr, npec_pkg::IDX_EVT_MASK);

  // ---------------------------------------------------------------
  // unlock key checkers
  // ---------------------------------------------------------------
  logic pul_set;
  logic dul_set;

  // program area: one unlock per reset, bad keys lock until reset
  npec_key_check #(
    .ONE_SHOT(1'b1)
  ) u_pkey (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(wr_pkey), // R7
    .key_byte(pwdata[7:0]),
    .unlock(pul_set)
  );

  // data area: bad keys allow a new attempt
  npec_key_check #(
    .ONE_SHOT(1'b0)
  ) u_dkey (
    .pclk(pclk),
    .presetn(presetn),
    .key_wr(wr_dkey), // R8
    .key_byte(pwdata[7:0]),
    .unlock(dul_set)
  );

  // ---------------------------------------------------------------
  // memory write arbitration
  // ---------------------------------------------------------------
  logic area_open;
  logic start;
  logic wpa_set;
  logic done;

  // protection per target area
  always_comb begin
    case (mem_req.area)
      npec_pkg::AREA_PROG: area_open = r_reg.pul;
      npec_pkg::AREA_DATA: area_open = r_reg.data_area_unlocked_flag;
      npec_pkg::AREA_OPT: area_open = r_reg.data_area_unlocked_flag & r_reg.option_write_enable; // R1
      default: area_open = 1'b0;
    endcase
  end

  // a write while busy is ignored; a blocked one is flagged
  assign start = mem_req.valid & ~busy & area_open;
  assign wpa_set = mem_req.valid & ~busy & ~area_open; // R13

  // last cycle of the last phase
  assign done = (r_reg.cnt == 16'h0000)
              & ((r_reg.op == npec_pkg::OP_PROG)
              | ((r_reg.op == npec_pkg::OP_ERASE) & ~r_reg.std));

  // ---------------------------------------------------------------
  // event status bits
  // ---------------------------------------------------------------
  logic [npec_pkg::EV_W-1:0] evt_set;
  logic [npec_pkg::EV_W-1:0] evt_nx;

  // sources of the sticky events
  always_comb begin
    evt_set = '0;
    evt_set[npec_pkg::EV_DONE] = done;
    evt_set[npec_pkg::EV_WPA] = wpa_set;
    evt_set[npec_pkg::EV_PUL] = pul_set;
    evt_set[npec_pkg::EV_DUL] = dul_set;
  end

  // write one to clear, a new event wins
  genvar g;
  generate
    for (g = 0; g < npec_pkg::EV_W; g = g + 1) begin : g_evt
      assign evt_nx[g] = evt_set[g] | (r_reg.evt[g] & ~(wr_evt & pwdata[g]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] stat_view;

  // status byte as software sees it
  always_comb begin
    stat_view = 8'h00;
    stat_view[npec_pkg::ST_HIGH_VOLTAGE_OFF_FLAG] = ~busy; // R9
    stat_view[npec_pkg::ST_DUL] = r_reg.data_area_unlocked_flag;
    stat_view[npec_pkg::ST_EOP] = r_reg.eop;
    stat_view[npec_pkg::ST_PUL] = r_reg.pul;
    stat_view[npec_pkg::ST_WPA] = r_reg.wpa;
  end

  // read multiplexer; key registers and unmapped words read zero
  always_comb begin
    rd_mux = 8'h00;
    if (reg_hit(paddr, npec_pkg::IDX_CTRL_A)) begin
      rd_mux = {4'h0, r_reg.ctrl_a};
    end else if (reg_hit(paddr, npec_pkg::IDX_CTRL_B)) begin
      rd_mux[npec_pkg::CB_OPT] = r_reg.option_write_enable;
      rd_mux[npec_pkg::CB_WORD] = r_reg.word;
      rd_mux[npec_pkg::CB_ERASE] = r_reg.erase;
      rd_mux[npec_pkg::CB_FAST] = r_reg.fast;
      rd_mux[npec_pkg::CB_STD] = r_reg.std;
    end else if (reg_hit(paddr, npec_pkg::IDX_STATUS)) begin
      rd_mux = stat_view;
    end else if (reg_hit(paddr, npec_pkg::IDX_EVT_STAT)) begin
      rd_mux = {4'h0, r_reg.evt};
    end else if (reg_hit(paddr, npec_pkg::IDX_EVT_MASK)) begin
      rd_mux = {4'h0, r_reg.mask};
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.accept = 1'b0;

    // read data and error are caught in the setup cycle
    if (setup) begin
      r_next.rdata = rd_mux; // R7 R8
      r_next.slverr = ~mapped;
    end

    // first control register
    if (wr_a) begin
      r_next.ctrl_a = pwdata[3:0];
    end

    // second control register; erase and fast bits frozen while busy
    if (wr_b) begin
      r_next.option_write_enable = pwdata[npec_pkg::CB_OPT]; // R1
      r_next.word = pwdata[npec_pkg::CB_WORD]; // R2
      r_next.std = pwdata[npec_pkg::CB_STD]; // R5
      if (!busy) begin
        r_next.erase = pwdata[npec_pkg::CB_ERASE]; // R3 R6
        r_next.fast = pwdata[npec_pkg::CB_FAST]; // R4 R6
      end
    end

    // writing zero relocks; a same-cycle unlock wins
    if (wr_stat && !pwdata[npec_pkg::ST_DUL]) begin
      r_next.data_area_unlocked_flag = 1'b0; // R10
    end
    if (wr_stat && !pwdata[npec_pkg::ST_PUL]) begin
      r_next.pul = 1'b0; // R11
    end
    if (dul_set) begin
      r_next.data_area_unlocked_flag = 1'b1; // R10
    end
    if (pul_set) begin
      r_next.pul = 1'b1; // R11 R16
    end

    // a status read clears only the flags it returned as set
    if (rd_stat && r_reg.rdata[npec_pkg::ST_EOP]) begin
      r_next.eop = 1'b0; // R12
    end
    if (rd_stat && r_reg.rdata[npec_pkg::ST_WPA]) begin
      r_next.wpa = 1'b0; // R13
    end
    if (wpa_set) begin
      r_next.wpa = 1'b1; // R13
    end

    // event status and mask
    r_next.evt = evt_nx;
    if (wr_mask) begin
      r_next.mask = pwdata[npec_pkg::EV_W-1:0];
    end

    // operation sequencer
    case (r_reg.op)
      npec_pkg::OP_IDLE: begin
        if (start) begin
          r_next.accept = 1'b1;
          r_next.eop = 1'b0; // R12
          if (r_reg.std || r_reg.erase) begin
            // standard block erases first
            r_next.op = npec_pkg::OP_ERASE; // R3 R5
            r_next.cnt = npec_pkg::ERASE_CYC - 16'h0001;
          end else if (r_reg.word) begin
            r_next.op = npec_pkg::OP_PROG; // R2
            r_next.cnt = npec_pkg::WORD_CYC - 16'h0001;
          end else begin
            // fast block, or a plain byte write
            r_next.op = npec_pkg::OP_PROG; // R4
            r_next.cnt = npec_pkg::PROG_CYC - 16'h0001;
          end
        end
      end
      npec_pkg::OP_ERASE: begin
        if (r_reg.cnt != 16'h0000) begin
          r_next.cnt = r_reg.cnt - 16'h0001;
        end else if (r_reg.std) begin
          r_next.op = npec_pkg::OP_PROG; // R5
          r_next.cnt = npec_pkg::PROG_CYC - 16'h0001;
        end else begin
          r_next.op = npec_pkg::OP_IDLE;
        end
      end
      npec_pkg::OP_PROG: begin
        if (r_reg.cnt != 16'h0000) begin
          r_next.cnt = r_reg.cnt - 16'h0001;
        end else begin
          r_next.op = npec_pkg::OP_IDLE;
        end
      end
      default: begin
        r_next.op = npec_pkg::OP_IDLE;
      end
    endcase

    // completion clears the request bits and raises done
    if (done) begin
      r_next.word = 1'b0; // R2
      r_next.erase = 1'b0; // R3
      r_next.fast = 1'b0; // R4
      r_next.std = 1'b0; // R5
      r_next.eop = 1'b1; // R12
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{op: npec_pkg::OP_IDLE, ctrl_a: npec_pkg::CTRL_A_RST,
                 mask: npec_pkg::EVT_MASK_RST, default: '0}; // R15
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // apb answer, zero wait states
  assign prdata = {24'h000000, r_reg.rdata};
  assign pready = 1'b1;
  assign pslverr = psel & penable & r_reg.slverr;

  // memory side status; high voltage on while an operation runs
  assign mem_stat = '{busy: busy,
                      hv_on: busy, // R9
                      accept: r_reg.accept};

  // level interrupt from the flags and from the masked events
  assign irq = (r_reg.ctrl_a[npec_pkg::CA_IRQ_EN] & (r_reg.eop | r_reg.wpa)) // R14
             | (|(r_reg.evt & r_reg.mask));

endmodule

// ==== tb/npec_ctrl_properties.sv ====
// port-level assertions for the nvm program/erase controller
`timescale 1ns/1ns
module npec_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire npec_pkg::npec_mem_req_type mem_req,
  input wire npec_pkg::npec_mem_stat_type mem_stat,
  input wire logic irq
);
  // -------------------------------------------------------------
  // helper: length of the current busy stretch
  // -------------------------------------------------------------
  logic [11:0] busy_len_reg;
  logic [11:0] busy_len_next;
  // counts cycles with busy high, restarts once it drops
  always_comb begin
    busy_len_next = mem_stat.busy ? busy_len_reg + 12'h001 : 12'h000;
  end
  // registers the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len_reg <= 12'h000;
    end else begin
      busy_len_reg <= busy_len_next;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  property p_pready;
    psel && penable |-> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready low in access phase");
  property p_slverr;
    psel && penable && (paddr[1:0] != 2'h0 || paddr[7:2] > 6'h06) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access without error");
  property p_key_read_zero;
    psel && penable && !pwrite && (paddr == 8'h08 || paddr == 8'h0c) |-> prdata == 32'h0;
  endproperty
  a_key_read_zero: assert property (p_key_read_zero) else $error("key register read not zero");
  property p_hv_flag;
    psel && !penable && !pwrite && paddr == 8'h10 |=> prdata[6] == !$past(mem_stat.hv_on);
  endproperty
  a_hv_flag: assert property (p_hv_flag) else $error("high voltage flag wrong");
  property p_hv_busy;
    mem_stat.hv_on == mem_stat.busy;
  endproperty
  a_hv_busy: assert property (p_hv_busy) else $error("high voltage not tied to busy");
  property p_accept_cause;
    mem_stat.accept |-> $past(mem_req.valid) && !$past(mem_stat.busy) && mem_stat.busy;
  endproperty
  a_accept_cause: assert property (p_accept_cause) else $error("accept without request");
  property p_busy_len;
    $fell(mem_stat.busy) |-> busy_len_reg == 12'h1f4 || busy_len_reg == 12'h3e8;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("operation length wrong");
  property p_ignore_busy;
    mem_stat.busy && mem_req.valid |=> !mem_stat.accept;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("write accepted while busy");
  c_accept: cover property (mem_stat.accept);
  c_done: cover property ($fell(mem_stat.busy));
  c_irq: cover property (irq);
  c_slverr: cover property (pslverr);
endmodule
bind npec_ctrl npec_ctrl_properties i_npec_ctrl_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_stat(mem_stat), .irq(irq));

// ==== tb/npec_ctrl_tb_top.sv ====
// self-checking bench for the nvm program/erase controller
`timescale 1ns/1ns
module npec_ctrl_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  npec_pkg::npec_mem_req_type mem_req = '0;
  npec_pkg::npec_mem_stat_type mem_stat;
  logic irq;
  logic [31:0] rd;
  logic last_err;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] bits [4] = '{8'h40, 8'h20, 8'h10, 8'h01};
  npec_ctrl i_npec_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_stat(mem_stat), .irq(irq));
  // -------------------------------------------------------------
  // clock and hang guard
  // -------------------------------------------------------------
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    tick(5);
    presetn <= 1'b1;
  endtask
  // one-cycle memory write attempt
  task automatic mem(input npec_pkg::npec_area_type ar);
    @(posedge pclk);
    mem_req <= '{valid: 1'b1, area: ar};
    @(posedge pclk);
    mem_req.valid <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (mem_stat.busy !== 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check("busy end", {31'h0, mem_stat.busy}, 32'h0);
  endtask
  task automatic unlock_data();
    apb(1'b1, 8'h0c, 32'h3c);
    apb(1'b1, 8'h0c, 32'hc3);
    tick(3);
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rdchk("reset value", 8'(i * 4), (i == 4) ? 32'h40 : 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped error", {31'h0, last_err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_keys();
    apb(1'b1, 8'h0c, 32'h55);
    unlock_data();
    rdchk("data unlock", 8'h10, 32'h48);
    rdchk("data key read", 8'h0c, 32'h0);
    apb(1'b1, 8'h08, 32'h3c);
    apb(1'b1, 8'h08, 32'hc3);
    tick(3);
    rdchk("prog unlock", 8'h10, 32'h4a);
    rdchk("prog key read", 8'h08, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    rdchk("relock", 8'h10, 32'h40);
    apb(1'b1, 8'h08, 32'h3c);
    apb(1'b1, 8'h08, 32'hc3);
    tick(3);
    rdchk("second unlock", 8'h10, 32'h40);
    do_reset();
    apb(1'b1, 8'h08, 32'h11);
    apb(1'b1, 8'h08, 32'h3c);
    apb(1'b1, 8'h08, 32'hc3);
    tick(3);
    rdchk("bad key lock", 8'h10, 32'h40);
    do_reset();
    $display("test keys done");
  endtask
  task automatic t_ops();
    unlock_data();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, {24'h0, bits[i]});
      mem(npec_pkg::AREA_DATA);
      rdchk("status busy", 8'h10, 32'h08);
      apb(1'b1, 8'h04, {24'h0, (bits[i] & 8'h41) | (~bits[i] & 8'h30)});
      rdchk("locked bits", 8'h04, {24'h0, bits[i]});
      wait_idle();
      rdchk("request cleared", 8'h04, 32'h0);
    end
    check("irq off", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h00, 32'h02);
    tick(1);
    check("irq on", {31'h0, irq}, 32'h1);
    rdchk("done flag", 8'h10, 32'h4c);
    tick(1);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdchk("done read clear", 8'h10, 32'h48);
    apb(1'b1, 8'h00, 32'h0);
    $display("test ops done");
  endtask
  task automatic t_prot();
    mem(npec_pkg::AREA_PROG);
    tick(2);
    rdchk("prot flag", 8'h10, 32'h41);
    rdchk("prot read clear", 8'h10, 32'h40);
    unlock_data();
    mem(npec_pkg::AREA_OPT);
    tick(2);
    check("option refused", {31'h0, mem_stat.busy}, 32'h0);
    rdchk("option flag", 8'h10, 32'h49);
    apb(1'b1, 8'h04, 32'h80);
    mem(npec_pkg::AREA_OPT);
    tick(2);
    check("option taken", {31'h0, mem_stat.busy}, 32'h1);
    wait_idle();
    rdchk("option done", 8'h10, 32'h4c);
    rdchk("events", 8'h14, 32'h0b);
    apb(1'b1, 8'h18, 32'h02);
    tick(1);
    check("event irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h18, 32'h0);
    tick(1);
    check("masked irq", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h18, 32'h02);
    apb(1'b1, 8'h14, 32'h02);
    tick(1);
    check("cleared irq", {31'h0, irq}, 32'h0);
    rdchk("events left", 8'h14, 32'h09);
    $display("test protection done");
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    do_reset();
    t_reset();
    t_keys();
    t_ops();
    do_reset();
    t_prot();
    summarize();
  end
endmodule
